// [bench/sss_host.sv]
`default_nettype none
// link-side host model: one byte request at a time plus start and
// stop markers, as a serial front end hands them to the block
module sss_host
  import sss_pkg::*;
(
  input  wire logic       link_clock,   // link clock
  input  wire logic       lk_busy,      // request pending
  input  wire logic [7:0] lk_rdata,     // answer byte
  output var  logic       lk_req_valid, // request strobe
  output var  sss_req_t   lk_req,       // request fields
  output var  logic       lk_start,     // start marker
  output var  logic       lk_stop,      // stop marker
  output var  logic       timed_out     // an answer never came
);
  timeunit 1ns;
  timeprecision 100ps;

  // idle until the bench asks for traffic
  initial begin
    lk_req_valid = 1'b0;
    lk_req       = '0;
    lk_start     = 1'b0;
    lk_stop      = 1'b0;
    timed_out    = 1'b0;
  end

  //////////////////////////////////////////////////////////////////////
  // one request; taken at the rising edge while busy is low
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] r);
    int n;
    @(negedge link_clock);
    lk_req       = '{wr: w, addr: a, data: d};
    lk_req_valid = 1'b1;
    @(negedge link_clock);
    lk_req_valid = 1'b0;
    // released fields must not look valid, so show their inverse
    lk_req       = ~lk_req;
    @(negedge link_clock);
    n = 0;
    // bounded wait for the answer
    while (lk_busy !== 1'b0 && n < 40) begin
      @(negedge link_clock);
      n++;
    end
    if (n >= 40) begin
      timed_out = 1'b1;
    end
    r = lk_rdata;
  endtask

  // one link-cycle start (0) or stop (1) marker
  task automatic pulse(input logic is_stop);
    @(negedge link_clock);
    if (is_stop) begin
      lk_stop = 1'b1;
    end else begin
      lk_start = 1'b1;
    end
    @(negedge link_clock);
    lk_stop  = 1'b0;
    lk_start = 1'b0;
  endtask
endmodule
`default_nettype wire

// [bench/sss_settings_test.sv]
`default_nettype none
`define CHK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("FAIL %0t got %0h exp %0h", $time, (got), (exp)); \
    end \
  end
module sss_settings_test
  import sss_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  // short counts keep the run brief
  localparam int AUTO_U = 20;
  localparam int RDY_U  = 10;
  localparam int STEP   = 2;
  localparam int PER    = 256 * STEP;  // pulse period in cycles

  logic                     clock, resetn, link_clock, link_resetn;
  logic                     lk_req_valid, lk_start, lk_stop, lk_busy;
  sss_req_t                 lk_req;
  logic [7:0]               lk_rdata, r;
  logic                     pwm_en, body_state_in, event_ready;
  logic [NUM_EVT-1:0]       evt_in;
  logic [NUM_RESEED_CH-1:0] halt_reseed_req, other_reseed_req, reseed_cmd;
  logic                     body_state_out, pulse_output_pin, window_open;
  logic                     inductive_transmit_en, force_normal_power;
  logic                     auto_switch_tick, tmo;
  int                       fails, samples_checked, hi, rs, tk;
  logic [7:0] rst_v [6] = '{8'h14, 8'h00, 8'h00, 8'h20, 8'h01, 8'h07};
  logic [7:0] wr_v  [6] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h81, 8'hff};
  logic [7:0] rb_v  [6] = '{8'ha5, 8'h3c, 8'h5a, 8'hc3, 8'h81, 8'h07};

  always #25 clock = ~clock;
  // link clock drifts against the system clock
  always #24 link_clock = ~link_clock;

  sss_settings #(.AUTO_UNIT_CYC_P(AUTO_U), .RDY_UNIT_CYC_P(RDY_U),
                 .PWM_STEP_CYC_P(STEP)) i_sss_settings (
    .clock(clock), .resetn(resetn), .link_clock(link_clock),
    .link_resetn(link_resetn), .lk_req_valid(lk_req_valid),
    .lk_req(lk_req), .lk_start(lk_start), .lk_stop(lk_stop),
    .lk_busy(lk_busy), .lk_rdata(lk_rdata), .pwm_en(pwm_en),
    .evt_in(evt_in), .body_state_in(body_state_in),
    .halt_reseed_req(halt_reseed_req), .other_reseed_req(other_reseed_req),
    .event_ready(event_ready), .body_state_out(body_state_out),
    .pulse_output_pin(pulse_output_pin),
    .inductive_transmit_en(inductive_transmit_en),
    .force_normal_power(force_normal_power),
    .auto_switch_tick(auto_switch_tick), .window_open(window_open),
    .reseed_cmd(reseed_cmd));

  sss_host i_sss_host (
    .link_clock(link_clock), .lk_busy(lk_busy), .lk_rdata(lk_rdata),
    .lk_req_valid(lk_req_valid), .lk_req(lk_req), .lk_start(lk_start),
    .lk_stop(lk_stop), .timed_out(tmo));

  //////////////////////////////////////////////////////////////////////
  // verdict, reached from the end and from any lost answer
  task automatic close_out();
    if (fails == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // register access; a lost answer ends the run
  task automatic rw(input logic w, input logic [7:0] a, input logic [7:0] d);
    i_sss_host.xfer(w, a, d, r);
    if (tmo === 1'b1) begin
      fails++;
      close_out();
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one-cycle pulses on event and reseed inputs; the caller samples the reply
  task automatic kick(input logic [6:0] e, input logic [2:0] h,
                      input logic [2:0] o);
    @(negedge clock);
    evt_in           = e;
    halt_reseed_req  = h;
    other_reseed_req = o;
    @(negedge clock);
    evt_in           = '0;
    halt_reseed_req  = '0;
    other_reseed_req = '0;
  endtask

  // high cycles, rising edges and ticks over n consecutive cycles
  task automatic measure(input int n);
    logic prev;
    prev = pulse_output_pin;
    hi = 0;
    rs = 0;
    tk = 0;
    repeat (n) begin
      @(negedge clock);
      if (pulse_output_pin === 1'b1) hi++;
      if (pulse_output_pin === 1'b1 && prev !== 1'b1) rs++;
      if (auto_switch_tick === 1'b1) tk++;
      prev = pulse_output_pin;
    end
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    clock = 1'b0;
    link_clock = 1'b1;
    resetn = 1'b0;
    link_resetn = 1'b0;
    pwm_en = 1'b0;
    evt_in = '0;
    body_state_in = 1'b0;
    halt_reseed_req = '0;
    other_reseed_req = '0;
    fails = 0;
    samples_checked = 0;
    cyc(3);
    resetn = 1'b1;
    @(negedge link_clock);
    link_resetn = 1'b1;
    repeat (3) @(negedge link_clock);
    // reset values, write/read back, unmapped offset
    for (int i = 0; i < 6; i++) begin
      rw(1'b0, ADDR_AUTO_TMR + i, 8'h00);
      `CHK(r, rst_v[i])
    end
    for (int i = 0; i < 6; i++) begin
      rw(1'b1, ADDR_AUTO_TMR + i, wr_v[i]);
      rw(1'b0, ADDR_AUTO_TMR + i, 8'h00);
      `CHK(r, rb_v[i])
    end
    rw(1'b1, 8'hdc, 8'h5a);
    rw(1'b0, 8'hdc, 8'h00);
    `CHK(r, 8'h00)
    // each mask bit blocks only its own source
    for (int i = 0; i < NUM_EVT; i++) begin
      logic [6:0] b;
      b = 7'h01 << i;
      rw(1'b1, ADDR_EVT_MASK, {1'b0, b});
      kick(b, 3'h0, 3'h0);
      `CHK(event_ready, 1'b0)
      kick(~b, 3'h0, 3'h0);
      `CHK(event_ready, 1'b1)
    end
    // state indication gated by the top mask bit
    body_state_in = 1'b1;
    rw(1'b1, ADDR_EVT_MASK, 8'h00);
    cyc(3);
    `CHK(body_state_out, 1'b1)
    rw(1'b1, ADDR_EVT_MASK, 8'h80);
    cyc(3);
    `CHK(body_state_out, 1'b0)
    // halt reseeds gated per channel, other reseeds never
    for (int i = 0; i < 2; i++) begin
      logic [2:0] en;
      en = (i == 0) ? 3'h5 : 3'h2;
      rw(1'b1, ADDR_RESEED_EN, {5'h00, en});
      kick(7'h00, 3'h7, 3'h0);
      `CHK(reseed_cmd, en)
      kick(7'h00, 3'h0, ~en);
      `CHK(reseed_cmd, ~en)
    end
    // pulse output held off until enabled
    cyc(PER);
    measure(PER);
    `CHK(hi, 0)
    `CHK(inductive_transmit_en, 1'b1)
    `CHK(force_normal_power, 1'b0)
    pwm_en = 1'b1;
    for (int i = 0; i < 3; i++) begin
      logic [7:0] d;
      d = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'hff;
      rw(1'b1, ADDR_DUTY, d);
      cyc(PER + 8);
      measure(PER);
      `CHK(hi, (int'(d) + 1) * STEP)
      `CHK(rs, (d == 8'hff) ? 0 : 1)
      `CHK(force_normal_power, 1'b1)
      `CHK(inductive_transmit_en, 1'b0)
    end
    // auto switch interval, including the disabled setting
    rw(1'b1, ADDR_AUTO_TMR, 8'h03);
    cyc(100);
    measure(600);
    `CHK(tk, 600 / (3 * AUTO_U))
    rw(1'b1, ADDR_AUTO_TMR, 8'h00);
    cyc(100);
    measure(300);
    `CHK(tk, 0)
    // stop closes the window while the option is clear
    rw(1'b1, ADDR_BUS_CFG, 8'h01);
    i_sss_host.pulse(1'b0);
    cyc(12);
    `CHK(window_open, 1'b1)
    i_sss_host.pulse(1'b1);
    cyc(12);
    `CHK(window_open, 1'b0)
    // option set: the window lingers for the timeout after a stop
    rw(1'b1, ADDR_BUS_CFG, 8'h81);
    for (int t = 4; t <= 8; t += 4) begin
      rw(1'b1, ADDR_RDY_TMO, 8'(t));
      i_sss_host.pulse(1'b0);
      cyc(12);
      i_sss_host.pulse(1'b1);
      cyc(t * RDY_U - 2);
      `CHK(window_open, 1'b1)
      cyc(16);
      `CHK(window_open, 1'b0)
    end
    // a start inside the linger keeps the window open
    i_sss_host.pulse(1'b0);
    cyc(12);
    i_sss_host.pulse(1'b1);
    cyc(20);
    i_sss_host.pulse(1'b0);
    cyc(8 * RDY_U + 20);
    `CHK(window_open, 1'b1)
    close_out();
  end
endmodule
`default_nettype wire

// [design/sss_settings.sv]
`default_nettype none
// How it works
// R1 - auto switch interval is field times 500ms
// R2 - mask bits 0-6 block their event sources
// R3 - mask bit 7 gates body-proximity state
// R4 - pulse high for duty plus one of 256
// R5 - fixed 1kHz pulse on third GPIO pin
// R6 - pulse only when power-mode enable set
// R7 - ready timeout is field times 0.32ms
// R8 - stop closes window when option clear
// R9 - option set: window ends after start timeout
// R10 - host always writes settings bit 0 as one
// R11 - host leaves settings bits 6-1 cleared
// R12 - reseed bits 2-0 enable channel reseeds
// R13 - reseed enables gate only halt-timeout reseeds
// R14 - pulse enable frees inductive pin, forces normal
// R15 - masked sources never raise ready indication
module sss_settings
  import sss_pkg::*;
#(
  parameter int unsigned AUTO_UNIT_CYC_P = AUTO_UNIT_CYC,
  parameter int unsigned RDY_UNIT_CYC_P  = RDY_UNIT_CYC,
  parameter int unsigned PWM_STEP_CYC_P  = PWM_STEP_CYC
) (
  input  wire logic                     clock,          // system clock
  input  wire logic                     resetn,         // sync reset, low
  input  wire logic                     link_clock,     // serial link clock
  input  wire logic                     link_resetn,    // link reset, low
  input  wire logic                     lk_req_valid,   // request pulse
  input  wire sss_req_t                 lk_req,         // request fields
  input  wire logic                     lk_start,       // start seen, pulse
  input  wire logic                     lk_stop,        // stop seen, pulse
  output logic                          lk_busy,        // request pending
  output logic [7:0]                    lk_rdata,       // last answer byte
  input  wire logic                     pwm_en,         // power-mode bit 7
  input  wire logic [NUM_EVT-1:0]       evt_in,         // event pulses
  input  wire logic                     body_state_in,  // activation level
  input  wire logic [NUM_RESEED_CH-1:0] halt_reseed_req, // halt timeouts
  input  wire logic [NUM_RESEED_CH-1:0] other_reseed_req, // other reseeds
  output logic                          event_ready,    // ready pulse
  output logic                          body_state_out, // gated state
  output logic                          pulse_output_pin, // 1kHz pulse
  output logic                          inductive_transmit_en, // coil ok
  output logic                          force_normal_power, // hold normal
  output logic                          auto_switch_tick, // interval pulse
  output logic                          window_open,    // comm window
  output logic [NUM_RESEED_CH-1:0]      reseed_cmd      // reseed pulses
);

  localparam int unsigned AW = $clog2(AUTO_UNIT_CYC_P + 1);
  localparam int unsigned RW = $clog2(RDY_UNIT_CYC_P + 1);
  localparam int unsigned PW = $clog2(PWM_STEP_CYC_P + 1);
  localparam logic [AW-1:0] AUTO_LAST = AW'(AUTO_UNIT_CYC_P - 1);
  localparam logic [RW-1:0] RDY_LAST  = RW'(RDY_UNIT_CYC_P - 1);
  localparam logic [PW-1:0] STEP_LAST = PW'(PWM_STEP_CYC_P - 1);

  ////////////////////////////////////////////////////////////////////////
  // link domain: request capture and toggle handshake
  sss_req_t   req_hold_r;     // stays still while a request is in flight
  logic       req_tgl_r;      // flips once per request
  logic       start_tgl_r;    // flips once per start
  logic       stop_tgl_r;     // flips once per stop
  logic [1:0] ack_sync_r;     // ack toggle into link domain
  logic       ack_seen_r;     // last ack consumed
  logic [7:0] rd_hold_r;      // sys domain answer, stable at ack

  // take a new request only when idle; extra requests are dropped
  always_ff @(posedge link_clock) begin
    if (!link_resetn) begin
      req_hold_r <= '0;
      req_tgl_r  <= 1'b0;
    end else if (lk_req_valid && !lk_busy) begin
      req_hold_r <= lk_req;
      req_tgl_r  <= ~req_tgl_r;
    end
  end

  // start and stop events leave as toggles so no pulse is lost
  always_ff @(posedge link_clock) begin
    if (!link_resetn) begin
      start_tgl_r <= 1'b0;
      stop_tgl_r  <= 1'b0;
    end else begin
      if (lk_start) start_tgl_r <= ~start_tgl_r;
      if (lk_stop)  stop_tgl_r  <= ~stop_tgl_r;
    end
  end

  // busy from capture until the core's ack returns
  always_ff @(posedge link_clock) begin
    if (!link_resetn) begin
      ack_sync_r <= 2'b00;
      ack_seen_r <= 1'b0;
      lk_busy    <= 1'b0;
      lk_rdata   <= RD_UNMAPPED;
    end else begin
      ack_sync_r <= {ack_sync_r[0], ack_tgl_r};
      if (lk_req_valid && !lk_busy) begin
        lk_busy <= 1'b1;
      end else if (ack_sync_r[1] != ack_seen_r) begin
        ack_seen_r <= ack_sync_r[1];
        lk_busy    <= 1'b0;
        lk_rdata   <= rd_hold_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // system domain: synchronisers and event detection
  logic [2:0] req_sync_r;     // [2] is the edge reference only
  logic [2:0] start_sync_r;
  logic [2:0] stop_sync_r;
  logic       ack_tgl_r;      // flips when a request is done
  logic       req_evt;        // request arrived
  logic       start_evt;      // start arrived
  logic       stop_evt;       // stop arrived

  always_ff @(posedge clock) begin
    if (!resetn) begin
      req_sync_r   <= 3'b000;
      start_sync_r <= 3'b000;
      stop_sync_r  <= 3'b000;
    end else begin
      req_sync_r   <= {req_sync_r[1:0], req_tgl_r};
      start_sync_r <= {start_sync_r[1:0], start_tgl_r};
      stop_sync_r  <= {stop_sync_r[1:0], stop_tgl_r};
    end
  end

  assign req_evt   = req_sync_r[2] ^ req_sync_r[1];
  assign start_evt = start_sync_r[2] ^ start_sync_r[1];
  assign stop_evt  = stop_sync_r[2] ^ stop_sync_r[1];

  ////////////////////////////////////////////////////////////////////////
  // register file
  sss_cfg_t cfg_r;            // all settings

  // read value of one offset; unmapped offsets read zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a,
                                        input sss_cfg_t c);
    logic [7:0] v;
    v = RD_UNMAPPED;
    if (a == ADDR_AUTO_TMR)       v = c.auto_tmr;
    else if (a == ADDR_EVT_MASK)  v = c.evt_mask;
    else if (a == ADDR_DUTY)      v = c.duty;
    else if (a == ADDR_RDY_TMO)   v = c.rdy_tmo;
    else if (a == ADDR_BUS_CFG)   v = c.bus_cfg;
    else if (a == ADDR_RESEED_EN) v = c.reseed_en;
    return v;
  endfunction

  // writes land here; reserved bits are never stored so they read zero
  always_ff @(posedge clock) begin
    if (!resetn) begin
      cfg_r.auto_tmr  <= RST_AUTO_TMR;
      cfg_r.evt_mask  <= RST_EVT_MASK;
      cfg_r.duty      <= RST_DUTY;
      cfg_r.rdy_tmo   <= RST_RDY_TMO;
      cfg_r.bus_cfg   <= RST_BUS_CFG;
      cfg_r.reseed_en <= RST_RESEED_EN;
    end else if (req_evt && req_hold_r.wr) begin
      if (req_hold_r.addr == ADDR_AUTO_TMR)
        cfg_r.auto_tmr <= req_hold_r.data;
      else if (req_hold_r.addr == ADDR_EVT_MASK)
        cfg_r.evt_mask <= req_hold_r.data;
      else if (req_hold_r.addr == ADDR_DUTY)
        cfg_r.duty <= req_hold_r.data;
      else if (req_hold_r.addr == ADDR_RDY_TMO)
        cfg_r.rdy_tmo <= req_hold_r.data;
      else if (req_hold_r.addr == ADDR_BUS_CFG)
        // bit 0 is stored as written; the host keeps it at one
        cfg_r.bus_cfg <= req_hold_r.data & BUS_CFG_MASK; // R10 R11
      else if (req_hold_r.addr == ADDR_RESEED_EN)
        cfg_r.reseed_en <= req_hold_r.data & RESEED_MASK; // R12
    end
  end

  // answer: read data (zero for writes) and the ack toggle, in the same cycle
  always_ff @(posedge clock) begin
    if (!resetn) begin
      rd_hold_r <= RD_UNMAPPED;
      ack_tgl_r <= 1'b0;
    end else if (req_evt) begin
      rd_hold_r <= req_hold_r.wr ? RD_UNMAPPED
                                 : rd_mux(req_hold_r.addr, cfg_r);
      ack_tgl_r <= ~ack_tgl_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event masking
  always_ff @(posedge clock) begin
    if (!resetn) begin
      event_ready    <= 1'b0;
      body_state_out <= 1'b0;
    end else begin
      event_ready    <= |(evt_in & ~cfg_r.evt_mask[NUM_EVT-1:0]); // R2 R15
      body_state_out <= body_state_in &
                        ~cfg_r.evt_mask[BODY_STATE_BIT]; // R3
    end
  end

  evt_mask_a: assert property (@(posedge clock) disable iff (!resetn) // R15
    event_ready |-> $past(|(evt_in & ~cfg_r.evt_mask[NUM_EVT-1:0])))
    else $error("ready raised by a masked source");
  body_state_a: assert property (@(posedge clock) disable iff (!resetn) // R3
    $past(cfg_r.evt_mask[BODY_STATE_BIT]) |-> !body_state_out)
    else $error("body state shown while masked");

  ////////////////////////////////////////////////////////////////////////
  // reseed gating: only halt-timeout reseeds obey the enables
  always_ff @(posedge clock) begin
    if (!resetn) begin
      reseed_cmd <= '0;
    end else begin
      reseed_cmd <= (halt_reseed_req &
                     cfg_r.reseed_en[NUM_RESEED_CH-1:0]) |
                    other_reseed_req; // R12 R13
    end
  end

  reseed_gate_a: assert property (@(posedge clock) disable iff (!resetn)
    reseed_cmd == $past((halt_reseed_req & // R13
      cfg_r.reseed_en[NUM_RESEED_CH-1:0]) | other_reseed_req))
    else $error("reseed command not gated by enables");

  ////////////////////////////////////////////////////////////////////////
  // pulse output: 256 steps per period, high for duty plus one steps
  logic [PW-1:0] step_cnt_r;  // cycles within one step
  logic [7:0]    step_idx_r;  // step within the period

  always_ff @(posedge clock) begin
    if (!resetn) begin
      step_cnt_r <= '0;
      step_idx_r <= '0;
    end else if (step_cnt_r == STEP_LAST) begin
      step_cnt_r <= '0;
      step_idx_r <= step_idx_r + 8'h01; // R5 wraps at 256 steps
    end else begin
      step_cnt_r <= step_cnt_r + PW'(1);
    end
  end

  // pin driven only while the power-mode enable is set
  always_ff @(posedge clock) begin
    if (!resetn) begin
      pulse_output_pin      <= 1'b0;
      inductive_transmit_en <= 1'b1;
      force_normal_power    <= 1'b0;
    end else begin
      pulse_output_pin      <= pwm_en && (step_idx_r <= cfg_r.duty); // R4 R6
      inductive_transmit_en <= !pwm_en; // R14
      force_normal_power    <= pwm_en;  // R14
    end
  end

  pwm_gate_a: assert property (@(posedge clock) disable iff (!resetn) // R6
    !$past(pwm_en) |-> !pulse_output_pin)
    else $error("pulse output without enable");
  pwm_duty_a: assert property (@(posedge clock) disable iff (!resetn) // R4
    $past(pwm_en) |-> pulse_output_pin ==
      ($past(step_idx_r) <= $past(cfg_r.duty)))
    else $error("pulse level disagrees with duty");
  coil_free_a: assert property (@(posedge clock) disable iff (!resetn)
    ##1 (inductive_transmit_en != force_normal_power)) // R14
    else $error("coil enable and normal hold both set");

  ////////////////////////////////////////////////////////////////////////
  // auto switch interval: a tick every field times 500ms, none at zero
  logic [AW-1:0] auto_cyc_r;  // cycles in a unit
  logic [7:0]    auto_units_r; // units elapsed

  always_ff @(posedge clock) begin
    if (!resetn) begin
      auto_cyc_r       <= '0;
      auto_units_r     <= '0;
      auto_switch_tick <= 1'b0;
    end else if (cfg_r.auto_tmr == 8'h00) begin
      auto_cyc_r       <= '0;
      auto_units_r     <= '0;
      auto_switch_tick <= 1'b0;
    end else if (auto_cyc_r == AUTO_LAST) begin
      auto_cyc_r <= '0;
      if (auto_units_r + 8'h01 >= cfg_r.auto_tmr) begin // R1
        auto_units_r     <= '0;
        auto_switch_tick <= 1'b1;
      end else begin
        auto_units_r     <= auto_units_r + 8'h01;
        auto_switch_tick <= 1'b0;
      end
    end else begin
      auto_cyc_r       <= auto_cyc_r + AW'(1);
      auto_switch_tick <= 1'b0;
    end
  end

  auto_tick_a: assert property (@(posedge clock) disable iff (!resetn) // R1
    auto_switch_tick |-> $past(auto_cyc_r) == AUTO_LAST &&
      $past(cfg_r.auto_tmr) != 8'h00)
    else $error("auto tick off a unit boundary");

  ////////////////////////////////////////////////////////////////////////
  // communication window with optional stop lingering
  sss_win_t      win_r;       // window state
  logic [RW-1:0] rdy_cyc_r;   // cycles in a timeout unit
  logic [7:0]    rdy_units_r; // units left

  always_ff @(posedge clock) begin
    if (!resetn) begin
      win_r       <= WIN_CLOSED;
      rdy_cyc_r   <= '0;
      rdy_units_r <= '0;
    end else begin
      case (win_r)
        WIN_CLOSED: begin
          if (start_evt) win_r <= WIN_OPEN;
        end
        WIN_OPEN: begin
          if (stop_evt && !cfg_r.bus_cfg[STOP_DIS_BIT]) begin
            win_r <= WIN_CLOSED; // R8
          end else if (stop_evt && cfg_r.rdy_tmo == 8'h00) begin
            win_r <= WIN_CLOSED; // R9 zero timeout
          end else if (stop_evt) begin
            win_r       <= WIN_LINGER; // R9
            rdy_cyc_r   <= '0;
            rdy_units_r <= cfg_r.rdy_tmo; // R7
          end
        end
        WIN_LINGER: begin
          if (start_evt) begin
            win_r <= WIN_OPEN; // R9 host came back in time
          end else if (rdy_cyc_r == RDY_LAST) begin
            rdy_cyc_r <= '0;
            if (rdy_units_r == 8'h01) win_r <= WIN_CLOSED; // R7 R9
            rdy_units_r <= rdy_units_r - 8'h01;
          end else begin
            rdy_cyc_r <= rdy_cyc_r + RW'(1);
          end
        end
        default: win_r <= WIN_CLOSED;
      endcase
    end
  end

  // window flag registered from state
  always_ff @(posedge clock) begin
    if (!resetn) window_open <= 1'b0;
    else         window_open <= (win_r != WIN_CLOSED);
  end

  stop_close_a: assert property (@(posedge clock) disable iff (!resetn)
    win_r == WIN_OPEN && stop_evt && !cfg_r.bus_cfg[STOP_DIS_BIT]
    |=> ##1 !window_open) // R8
    else $error("stop did not close the window");
  stop_hold_a: assert property (@(posedge clock) disable iff (!resetn)
    win_r == WIN_OPEN && stop_evt && cfg_r.bus_cfg[STOP_DIS_BIT] &&
    cfg_r.rdy_tmo != 8'h00 |=> ##1 window_open) // R9
    else $error("stop closed window while disabled");
  linger_end_a: assert property (@(posedge clock) disable iff (!resetn)
    win_r == WIN_LINGER && !start_evt && rdy_cyc_r == RDY_LAST &&
    rdy_units_r == 8'h01 |=> win_r == WIN_CLOSED) // R7
    else $error("timeout did not close the window");

endmodule
`default_nettype wire

// [inc/sss_pkg.sv]
`default_nettype none
package sss_pkg;
  // clock and timing figures
  localparam int unsigned SYS_CLK_HZ     = 20_000_000;
  localparam int unsigned AUTO_UNIT_MS   = 500;      // auto switch step
  localparam int unsigned RDY_UNIT_NS    = 320_000;  // ready timeout step
  localparam int unsigned PWM_FREQ_HZ    = 1000;     // fixed pulse rate
  localparam int unsigned PWM_STEPS      = 256;      // duty resolution
  localparam int unsigned SYS_CLK_NS     = 1_000_000_000 / SYS_CLK_HZ;
  localparam int unsigned AUTO_UNIT_CYC  = SYS_CLK_HZ / 1000 * AUTO_UNIT_MS;
  localparam int unsigned RDY_UNIT_CYC   = RDY_UNIT_NS / SYS_CLK_NS;
  localparam int unsigned PWM_PERIOD_CYC = SYS_CLK_HZ / PWM_FREQ_HZ;
  localparam int unsigned PWM_STEP_CYC   = PWM_PERIOD_CYC / PWM_STEPS;
  // register offsets
  localparam logic [7:0] ADDR_AUTO_TMR   = 8'hd6;
  localparam logic [7:0] ADDR_EVT_MASK   = 8'hd7;
  localparam logic [7:0] ADDR_DUTY       = 8'hd8;
  localparam logic [7:0] ADDR_RDY_TMO    = 8'hd9;
  localparam logic [7:0] ADDR_BUS_CFG    = 8'hda;
  localparam logic [7:0] ADDR_RESEED_EN  = 8'hdb;
  // reset values
  localparam logic [7:0] RST_AUTO_TMR    = 8'h14;
  localparam logic [7:0] RST_EVT_MASK    = 8'h00;
  localparam logic [7:0] RST_DUTY        = 8'h00;
  localparam logic [7:0] RST_RDY_TMO     = 8'h20;
  localparam logic [7:0] RST_BUS_CFG     = 8'h01;
  localparam logic [7:0] RST_RESEED_EN   = 8'h07;
  // field layout
  localparam int unsigned NUM_EVT        = 7;  // maskable event sources
  localparam int unsigned BODY_STATE_BIT = 7;  // state indication mask
  localparam int unsigned STOP_DIS_BIT   = 7;  // stop handling option
  localparam int unsigned NUM_RESEED_CH  = 3;  // reseed channels
  localparam logic [7:0]  BUS_CFG_MASK   = 8'h81; // stored bits only
  localparam logic [7:0]  RESEED_MASK    = 8'h07;
  localparam logic [7:0]  RD_UNMAPPED    = 8'h00;

  // one request from the serial front end
  typedef struct packed {
    logic       wr;    // 1 write, 0 read
    logic [7:0] addr;  // register offset
    logic [7:0] data;  // write byte
  } sss_req_t;

  // settings as seen by the core
  typedef struct packed {
    logic [7:0] auto_tmr;
    logic [7:0] evt_mask;
    logic [7:0] duty;
    logic [7:0] rdy_tmo;
    logic [7:0] bus_cfg;
    logic [7:0] reseed_en;
  } sss_cfg_t;

  typedef enum logic [1:0] {WIN_CLOSED, WIN_OPEN, WIN_LINGER} sss_win_t;
endpackage
`default_nettype wire
